// file: verilog/dls_link.sv
// Seven-to-one display link: transmitter, receiver and input buffer
// Operation
// (R1) Take one pixel word every pixel period
// (R2) Spread 21 bits over three lanes
// (R3) Lanes run at seven bits per pixel
// (R4) Slots fill successive sevenths of period
// (R5) Send phase locked link clock lane
// (R6) Pixel period stays within 15..50 ns; code takes seven 10 ns core cycles, 70 ns
// (R7) Input word strobed at one clock edge
// (R8) Word holds colour plus three sync bits
// (R9) Colour split into three 6-bit fields
// (R10) Receiver rebuilds word per link period
// (R11) Strobe falling edge marks valid output
// (R12) Receiver sleep holds previous outputs
// (R13) Transmitter sleep stops and releases link
// (R14) Transmitter waits lock time before driving
// (R15) Receiver waits lock time before output
// (R16) Fixed shared lane and slot mapping
// (R17) Link clock rises once at slot zero
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Input buffer
// ------------------------------------------------------------------
module dls_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Filling side
   input wire logic [WIDTH-1:0] i_in_data,
   input wire logic i_in_valid,
   output logic o_in_ready,
   // Draining side
   output logic [WIDTH-1:0] o_out_data,
   output logic o_out_valid,
   input wire logic i_out_ready
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   // All buffer state in one record
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Entries
      logic [PTR_W-1:0] wptr;           // Next write slot
      logic [PTR_W-1:0] rptr;           // Next read slot
      logic [CNT_W-1:0] count;          // Entries held
      logic in_ready;                   // Registered not-full
   } dls_fifo_state_t;

   dls_fifo_state_t q;
   dls_fifo_state_t d;
   logic wr_fire;
   logic rd_fire;

   // Handshakes on both sides
   assign wr_fire = i_in_valid && q.in_ready;
   assign rd_fire = i_out_ready && (q.count != '0);
   assign o_in_ready = q.in_ready;
   assign o_out_valid = (q.count != '0);
   assign o_out_data = q.mem[q.rptr];

   // Next state
   always_comb begin
      d = q;
      if (wr_fire) begin
         d.mem[q.wptr] = i_in_data;
         d.wptr = (q.wptr == PTR_W'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
      end
      if (rd_fire) begin
         d.rptr = (q.rptr == PTR_W'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
      end
      // Count moves only when one side fires alone
      if (wr_fire && !rd_fire) begin
         d.count = q.count + 1'b1;
      end else if (rd_fire && !wr_fire) begin
         d.count = q.count - 1'b1;
      end
      // Full means count equals depth; no off-by-one slack is kept
      // Ready looks one cycle ahead so it can be a flop
      d.in_ready = (d.count != CNT_W'(DEPTH));
   end

   // State register
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : dls_fifo

// ------------------------------------------------------------------
// Top: transmitter on i_clock, receiver split over two domains
// ------------------------------------------------------------------
module dls_link #(
   parameter int TX_LOCK_CYCLES = dls_pkg::PLL_LOCK_CYCLES,
   parameter int RX_LOCK_CYCLES = dls_pkg::PLL_LOCK_CYCLES
) (
   // Core clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Transmitter pixel input
   input wire dls_pkg::dls_pixel_t i_parallel_pixel_in,
   input wire logic i_pixel_in_valid,
   output logic o_pixel_in_ready,
   input wire logic i_tx_sleep_request_n,
   // Transmitter link output
   output logic [dls_pkg::LANES-1:0] o_serial_lane_out,
   output logic o_link_clock_out,
   output logic o_link_out_en,
   // Receiver link input, sampled on the link bit clock
   input wire logic i_link_bit_clock,
   input wire logic [dls_pkg::LANES-1:0] i_serial_lane_in,
   input wire logic i_link_clock_in,
   // Receiver pixel output
   input wire logic i_rx_sleep_request_n,
   output dls_pkg::dls_pixel_t o_parallel_pixel_out,
   output logic o_recovered_pixel_strobe,
   output logic o_rx_locked
);
   localparam int NL = dls_pkg::LANES;
   localparam int NS = dls_pkg::SLOTS;
   localparam int WW = dls_pkg::WORD_W;
   localparam int LW = dls_pkg::LOCK_CNT_W;

   // ---------------------------------------------------------------
   // Core-domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] tx_wake_s;       // Sleep input synchroniser
      logic [LW-1:0] tx_lock_cnt;  // Lock wait counter
      logic tx_locked;             // Lock time elapsed
      logic [2:0] slot;            // Current bit slot
      dls_pkg::dls_pixel_t word;   // Word on the lanes
      logic [NL-1:0] lane;         // Lane pins
      logic lclk;                  // Link clock pin
      logic oe;                    // Link drive enable
      logic [1:0] rx_wake_s;       // Receiver sleep synchroniser
      logic [2:0] tog_s;           // Word toggle sync plus history
      logic [LW-1:0] rx_lock_cnt;  // Receiver lock counter
      logic rx_seen;               // Link activity observed
      logic rx_locked;             // Receiver lock time elapsed
      dls_pkg::dls_pixel_t pix;    // Held output word
      logic strobe;                // Pixel strobe pin
   } dls_core_t;

   // ---------------------------------------------------------------
   // Link-domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      dls_pkg::dls_link_t s1;      // First sync stage
      dls_pkg::dls_link_t s2;      // Second sync stage
      logic clk_prev;              // Last sampled clock lane
      logic [2:0] slot;            // Slot of the sample just taken
      logic [WW-1:0] acc;          // Word under assembly
      logic [WW-1:0] word;         // Last complete word
      logic tog;                   // Flips per complete word
   } dls_lnk_t;

   dls_core_t q;
   dls_core_t d;
   dls_lnk_t lq;
   dls_lnk_t ld;
   logic [1:0] lrst_s;             // Reset carried into link domain
   logic [WW-1:0] fifo_word;
   logic fifo_valid;
   logic fifo_pop;
   logic [2:0] tx_ns;
   logic [WW-1:0] tx_nw;
   logic [NL-1:0] tx_nlane;
   logic [2:0] rx_ns;
   logic [WW-1:0] rx_nacc;
   logic tx_wake;
   logic rx_wake;
   logic rx_evt;

   // Only the second synchroniser stage feeds logic
   assign tx_wake = q.tx_wake_s[1];
   assign rx_wake = q.rx_wake_s[1];

   // ---------------------------------------------------------------
   // Input buffer; its ready stalls the graphics source
   // ---------------------------------------------------------------
   dls_fifo #(
      .WIDTH(WW),
      .DEPTH(dls_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_in_data(i_parallel_pixel_in), // R7 R8
      .i_in_valid(i_pixel_in_valid),
      .o_in_ready(o_pixel_in_ready),
      .o_out_data(fifo_word),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop)
   );

   // One word leaves the buffer as the last slot ends
   assign fifo_pop = q.tx_locked && tx_wake && (q.slot == dls_pkg::SLOT_LAST); // R1

   // Slot walk; unlocked holds at the last slot so lock starts a period
   assign tx_ns = (q.slot == dls_pkg::SLOT_LAST) ? '0 : q.slot + 1'b1; // R3 R4 R6
   // Empty buffer sends a blank word with pixel_valid low
   assign tx_nw = (q.slot == dls_pkg::SLOT_LAST) ?
                  (fifo_valid ? fifo_word : '0) : q.word; // R1

   // Lane l slot s carries word bit l*7+s
   for (genvar l = 0; l < NL; l++) begin : g_tx_lane
      assign tx_nlane[l] = tx_nw[l * NS + int'(tx_ns)]; // R2 R16
   end

   // ---------------------------------------------------------------
   // Link-domain deserializer
   // ---------------------------------------------------------------
   // Clock lane rising marks slot 0; past slot 6 framing is lost
   assign rx_ns = (lq.s2.clock && !lq.clk_prev) ? '0 :
                  (lq.slot == dls_pkg::SLOT_LOST) ? lq.slot : lq.slot + 1'b1; // R17

   // Each sampled lane bit lands at its shared position
   for (genvar b = 0; b < WW; b++) begin : g_rx_bit
      assign rx_nacc[b] = (int'(rx_ns) == b % NS) ? lq.s2.lane[b / NS] : lq.acc[b]; // R16
   end

   // Link-domain next state
   always_comb begin
      ld = lq;
      ld.s1 = {i_serial_lane_in, i_link_clock_in};
      ld.s2 = lq.s1;
      ld.clk_prev = lq.s2.clock;
      ld.slot = rx_ns;
      ld.acc = rx_nacc;
      // Slot 6 closes the word; hand it over with a toggle
      if (rx_ns == dls_pkg::SLOT_LAST) begin
         ld.word = rx_nacc; // R10
         ld.tog = !lq.tog; // R10
      end
   end

   // Reset must span a few link edges or the link side starts unknown
   // Reset crossing into the link domain, no logic on stage one
   always_ff @(posedge i_link_bit_clock) begin
      lrst_s <= {lrst_s[0], i_rst};
   end

   // Link-domain register
   always_ff @(posedge i_link_bit_clock) begin
      if (lrst_s[1]) begin
         lq <= '0;
         lq.slot <= dls_pkg::SLOT_LOST;
      end else begin
         lq <= ld;
      end
   end

   // Toggle edge; word has been stable for two cycles by then
   assign rx_evt = q.tog_s[1] ^ q.tog_s[2];

   // ---------------------------------------------------------------
   // Core-domain next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.tx_wake_s = {q.tx_wake_s[0], i_tx_sleep_request_n};
      d.rx_wake_s = {q.rx_wake_s[0], i_rx_sleep_request_n};
      d.tog_s = {q.tog_s[1:0], lq.tog};
      // Transmitter
      if (!tx_wake) begin
         // Sleep: stop, release the link, restart the lock wait
         d.tx_lock_cnt = '0; // R13
         d.tx_locked = 1'b0; // R13
         d.slot = dls_pkg::SLOT_LAST; // R13
         d.lane = '0; // R13
         d.lclk = 1'b0; // R13
         d.oe = 1'b0; // R13
      end else if (!q.tx_locked) begin
         // Link stays released until lock time has run
         d.tx_lock_cnt = q.tx_lock_cnt + 1'b1; // R14
         d.tx_locked = (q.tx_lock_cnt == LW'(TX_LOCK_CYCLES - 1)); // R14
      end else begin
         d.slot = tx_ns; // R3
         d.word = tx_nw; // R1
         d.lane = tx_nlane; // R2
         // High for slots 0..3, one rise per period
         d.lclk = (int'(tx_ns) < dls_pkg::CLK_HIGH_SLOTS); // R5 R17
         d.oe = 1'b1; // R14
      end
      // Receiver lock: needs wake and link activity first
      d.strobe = 1'b0; // R11
      if (!rx_wake) begin
         d.rx_lock_cnt = '0; // R15
         d.rx_locked = 1'b0; // R15
         d.rx_seen = 1'b0; // R15
      end else if (!q.rx_seen) begin
         d.rx_seen = rx_evt; // R15
      end else if (!q.rx_locked) begin
         d.rx_lock_cnt = q.rx_lock_cnt + 1'b1; // R15
         d.rx_locked = (q.rx_lock_cnt == LW'(RX_LOCK_CYCLES - 1)); // R15
      end
      // New word with a one-cycle strobe; sleep leaves pix alone
      if (rx_wake && q.rx_locked && rx_evt) begin
         d.pix = lq.word; // R9 R12
         d.strobe = 1'b1; // R11
      end
   end

   // Core-domain register
   // Reset parks the slot at the last so lock starts a clean period
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         q <= '0;
         q.slot <= dls_pkg::SLOT_LAST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flops
   assign o_serial_lane_out = q.lane;
   assign o_link_clock_out = q.lclk;
   assign o_link_out_en = q.oe;
   assign o_parallel_pixel_out = q.pix; // R9
   assign o_recovered_pixel_strobe = q.strobe;
   assign o_rx_locked = q.rx_locked;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   a_clock_rise_period: assert property ($rose(o_link_clock_out) |=> // R17
      (!$rose(o_link_clock_out))[*6] ##1 ($rose(o_link_clock_out) || !o_link_out_en))
      else $error("link clock rise spacing is not seven cycles");
   // Sleep may cut a period short, so only fully awake high phases are judged
   a_clock_high_slots: assert property ($rose(o_link_clock_out) ##0 tx_wake[*3] |-> // R4
      $past(o_link_clock_out, 2) && $past(o_link_clock_out) && o_link_clock_out ##1
      o_link_clock_out ##1 !o_link_clock_out)
      else $error("link clock high time is not four slots");
   a_sleep_release: assert property (!tx_wake |=> !o_link_out_en && // R13
      o_serial_lane_out == '0 && !o_link_clock_out)
      else $error("link still driven in sleep");
   a_lock_wait_tx: assert property ($rose(q.tx_locked) |-> // R14
      $past(q.tx_lock_cnt) == LW'(TX_LOCK_CYCLES - 1))
      else $error("transmitter lock wait length wrong");
   a_slot0_mapping: assert property ($rose(o_link_clock_out) |-> // R16
      o_serial_lane_out == {q.word[2 * NS], q.word[NS], q.word[0]})
      else $error("slot zero lane bits do not match word");
   a_one_pop_period: assert property (fifo_pop |=> !fifo_pop[*6]) // R1
      else $error("more than one word taken per period");
   a_rx_sleep_hold: assert property (!rx_wake |=> $stable(o_parallel_pixel_out)) // R12
      else $error("receiver output changed in sleep");
   a_strobe_pulse: assert property (o_recovered_pixel_strobe |=> // R11
      !o_recovered_pixel_strobe && $stable(o_parallel_pixel_out))
      else $error("pixel strobe wider than one cycle");
   a_rx_lock_gate: assert property ($rose(o_recovered_pixel_strobe) |-> // R15
      $past(q.rx_locked) && $past(rx_wake))
      else $error("pixel strobe before receiver lock");
   a_en_needs_lock: assert property (o_link_out_en |-> q.tx_locked) // R14
      else $error("link driven before lock wait ended");
   a_sleep_no_strobe: assert property (!rx_wake |=> !o_recovered_pixel_strobe) // R12
      else $error("pixel strobe while receiver asleep");

   // Main scenarios the bench is expected to reach
   c_tx_word_sent: cover property (fifo_pop && fifo_valid ##7 fifo_pop && fifo_valid);
   c_tx_sleep_entry: cover property (o_link_out_en ##1 !o_link_out_en);
   c_fifo_full: cover property (!o_pixel_in_ready && i_pixel_in_valid);
   c_rx_word_out: cover property (o_recovered_pixel_strobe ##[1:20] o_recovered_pixel_strobe);
   c_rx_sleep_hold: cover property (q.rx_locked ##1 !rx_wake);
endmodule : dls_link

// file: pkg/dls_pkg.sv
// Shared constants and carriers for the seven-to-one display link
package dls_pkg;

   // ---------------------------------------------------------------
   // Link geometry
   // ---------------------------------------------------------------
   localparam int LANES = 3;            // Serial data lanes
   localparam int SLOTS = 7;            // Bit slots per pixel period
   localparam int WORD_W = 21;          // Parallel word width
   localparam int COLOR_W = 6;          // One colour field
   localparam int SLOT_W = 3;           // Slot counter width
   localparam int CLK_HIGH_SLOTS = 4;   // Link clock high for slots 0..3
   localparam logic [2:0] SLOT_LAST = 3'h6; // Final slot index
   localparam logic [2:0] SLOT_LOST = 3'h7; // Framing lost marker

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;      // Core clock period
   localparam int PIXEL_PERIOD_MIN_NS = 15;  // Shortest pixel period
   localparam int PIXEL_PERIOD_MAX_NS = 50;  // Longest pixel period
   localparam int PLL_LOCK_TIME_MS = 10;     // Longest lock time
   // Longest lock time, rounded up to whole cycles
   localparam int PLL_LOCK_CYCLES =
      (PLL_LOCK_TIME_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int LOCK_CNT_W = 20;           // Holds up to 1_048_575
   localparam int FIFO_DEPTH = 4;            // Input buffer depth

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   // 18 colour bits plus 3 timing bits, bit 0 is pixel_valid
   typedef struct packed {
      logic [COLOR_W-1:0] red;
      logic [COLOR_W-1:0] green;
      logic [COLOR_W-1:0] blue;
      logic line_sync;
      logic frame_sync;
      logic pixel_valid;
   } dls_pixel_t;

   // Serial side of the link, one bit per lane plus the clock lane
   typedef struct packed {
      logic [LANES-1:0] lane;
      logic clock;
   } dls_link_t;

endpackage : dls_pkg

// file: tb/dls_link_src.sv
// Far-side link transmitter model that feeds the receiver lanes
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Link source model
// ------------------------------------------------------------------
module dls_link_src (
   // Link clock and reset
   input wire logic i_link_bit_clock,
   input wire logic i_rst,
   // Word to send, repeated while i_send is high
   input wire logic i_send,
   input wire dls_pkg::dls_pixel_t i_word,
   // Serial lanes toward the receiver
   output logic [dls_pkg::LANES-1:0] o_lane,
   output logic o_clock_lane
);
   logic [2:0] slot; // Current bit slot
   logic [20:0] word; // Word latched at slot zero

   initial begin
      slot = 3'h0;
      word = '0;
      o_lane = 3'h0;
      o_clock_lane = 1'b0;
   end

   // One slot per link edge, driven a little after the edge
   always @(posedge i_link_bit_clock) begin
      #1;
      if (i_rst || !i_send) begin
         // Clock lane stands still; data toggles so stale bits never look valid
         slot = 3'h0;
         o_clock_lane = 1'b0;
         o_lane = ~o_lane;
      end else begin
         if (slot == 3'h0) begin
            word = i_word;
         end
         o_clock_lane = (slot < 3'h4);
         for (int l = 0; l < dls_pkg::LANES; l++) begin
            o_lane[l] = word[l * 7 + slot];
         end
         slot = (slot == 3'h6) ? 3'h0 : slot + 3'h1;
      end
   end
endmodule : dls_link_src

// file: tb/dls_link_bench.sv
// Self-checking bench for the seven-to-one display link
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Bench top
// ------------------------------------------------------------------
module dls_link_bench;
   localparam int LOCK = 20; // Shortened lock wait
   logic i_clock, i_rst, link_clk, valid, tx_sleep_n, rx_sleep_n, send;
   logic ready, lck_out, en, strobe, locked, clk_lane, full_seen;
   logic [2:0] lanes_out, lanes_in;
   dls_pkg::dls_pixel_t pix_in, src_word, pix_out, hold;
   logic [20:0] got;
   logic [20:0] exp_q[$];
   logic [7:0] seed;
   int errors, checks, cycles, slot, seen;
   logic tx_prev;

   dls_link #(.TX_LOCK_CYCLES(LOCK), .RX_LOCK_CYCLES(LOCK)) uut (.i_clock(i_clock),
      .i_rst(i_rst), .i_parallel_pixel_in(pix_in), .i_pixel_in_valid(valid),
      .o_pixel_in_ready(ready), .i_tx_sleep_request_n(tx_sleep_n),
      .o_serial_lane_out(lanes_out), .o_link_clock_out(lck_out), .o_link_out_en(en),
      .i_link_bit_clock(link_clk), .i_serial_lane_in(lanes_in), .i_link_clock_in(clk_lane),
      .i_rx_sleep_request_n(rx_sleep_n), .o_parallel_pixel_out(pix_out),
      .o_recovered_pixel_strobe(strobe), .o_rx_locked(locked));
   dls_link_src src (.i_link_bit_clock(link_clk), .i_rst(i_rst), .i_send(send),
      .i_word(src_word), .o_lane(lanes_in), .o_clock_lane(clk_lane));

   // Even phase offset keeps link edges off the core clock rising edges
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   initial begin
      link_clk = 1'b0;
      #2;
      forever #6 link_clk = ~link_clk;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   // Random word; the valid bit is set so it never matches a blank word
   function automatic logic [20:0] rand_word();
      logic [23:0] r;
      r = '0;
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         r = {r[15:0], seed};
      end
      return {r[20:1], 1'b1};
   endfunction : rand_word

   task automatic check(input string name, input logic [20:0] sv, input logic [20:0] ev);
      checks++;
      if (sv !== ev) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, ev, sv);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   // Count cycles until the link drives, then judge the lock wait
   task automatic wait_lock();
      int n;
      n = 0;
      while (en !== 1'b1 && n < 100) begin
         @(posedge i_clock);
         n++;
      end
      check("lock_wait", 21'(n >= LOCK && n <= LOCK + 6), 21'(1));
   endtask : wait_lock

   // Offer k random words back to back, holding each until taken
   task automatic burst(input int k);
      for (int i = 0; i < k; i++) begin
         #1 valid = 1'b1;
         pix_in = rand_word();
         do begin
            @(posedge i_clock);
            if (ready !== 1'b1) full_seen = 1'b1;
         end while (ready !== 1'b1);
         exp_q.push_back(pix_in);
      end
      #1 valid = 1'b0;
      for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge i_clock);
      check("all_sent", 21'(exp_q.size()), 21'(0));
   endtask : burst

   // Wait for a strobe, then see it fall on the next edge
   task automatic wait_strobe();
      int n;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (strobe !== 1'b1 && n < 200);
      check("strobe_seen", 21'(strobe), 21'(1));
      @(posedge i_clock);
      check("strobe_fall", 21'(strobe), 21'(0));
   endtask : wait_strobe

   // ------------------------------------------------------------------
   // Monitors: lane decoder and timeout
   // ------------------------------------------------------------------
   always @(posedge i_clock) begin
      if (en === 1'b1) begin
         if (lck_out && !tx_prev) slot = 0;
         else if (slot < 7) slot++;
         if (slot < 7) begin
            check("link_clock", 21'(lck_out), 21'(slot < 4));
            for (int l = 0; l < 3; l++) got[l * 7 + slot] = lanes_out[l];
            if (slot == 6 && got != 0) begin
               check("tx_word", got, exp_q.size() ? exp_q.pop_front() : 'x);
            end
         end
      end
      tx_prev = lck_out;
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      {errors, checks, cycles, seen} = '0;
      slot = 7;
      tx_prev = 1'b0;
      seed = 8'h54;
      {valid, send, full_seen} = '0;
      {i_rst, tx_sleep_n, rx_sleep_n} = 3'h7;
      pix_in = '0;
      src_word = '0;
      got = '0;
      // Three cycles still span two link edges, enough for its two-stage carry
      repeat (3) @(posedge i_clock);
      #1 i_rst = 1'b0;
      @(posedge i_clock);
      check("en_at_reset", 21'(en), 21'(0));
      wait_lock();
      $display("test lock done");
      burst(6);
      check("buffer_full", 21'(full_seen), 21'(1));
      $display("test transmit done");
      #1 tx_sleep_n = 1'b0;
      repeat (5) @(posedge i_clock);
      check("sleep_link", 21'({en, lck_out, lanes_out}), 21'(0));
      #1 tx_sleep_n = 1'b1;
      wait_lock();
      burst(2);
      $display("test tx sleep done");
      #1 src_word = rand_word();
      send = 1'b1;
      for (int n = 0; n < 400 && locked !== 1'b1; n++) @(posedge i_clock);
      check("rx_locked", 21'(locked), 21'(1));
      for (int w = 0; w < 4; w++) begin
         #1 src_word = rand_word();
         repeat (3) wait_strobe();
         check("rx_word", pix_out, src_word);
      end
      $display("test receive done");
      #1 rx_sleep_n = 1'b0;
      repeat (5) @(posedge i_clock);
      hold = pix_out;
      #1 src_word = rand_word();
      repeat (150) begin
         @(posedge i_clock);
         seen += int'(strobe);
      end
      check("sleep_strobes", 21'(seen), 21'(0));
      check("sleep_hold", pix_out, hold);
      #1 rx_sleep_n = 1'b1;
      repeat (3) wait_strobe();
      check("wake_word", pix_out, src_word);
      #1 send = 1'b0;
      // Let the cut frame and any word in flight drain before counting
      repeat (30) @(posedge i_clock);
      seen = 0;
      repeat (150) begin
         @(posedge i_clock);
         seen += int'(strobe);
      end
      check("no_framing", 21'(seen), 21'(0));
      $display("test rx sleep done");
      tally_and_finish();
   end
endmodule : dls_link_bench
